// >>> rtl/slci_pkg.sv
// Constants, types and shared decoding for the serial character display command interpreter.
// Overview of operation
// - Plain bytes outside sequences become character writes.
// - Bytes 0x08-0x0F outside glyph mode start a sequence, never displayed.
// - 0x0F acts alone; other prefixes take one value.
// - Prefix 0x08 sends next byte as instruction.
// - Set select, present byte, then pulse enable.
// - After prefix and value, resume normal interpretation.
// - Busy flag never read; fixed wait per write.
// - Clear/home wait 2.7 ms, others 80 us.
// - Continuous delay never alters the long wait.
// - Prefix 0x09 forces next byte as character data.
// - Prefix 0x0A sets one-shot wait in 10 us units.
// - Prefix 0x0B sets persistent wait until changed.
// - Prefix 0x0C pauses once without any display write.
// - Instruction 0x40-0x7F enters glyph write mode.
// - Byte 0xF0 leaves glyph mode; else glyph data.
// - Instruction 0x80-0xFF positions cursor for later text.
// - Block leaves reset by itself, ready for bytes.
// - Select low for instructions, high for data.
// - Enable strobe lasts about 3 us.
// - Serial bytes are 8N1, LSB first, two rates.
// - Prefixes 0x0D, 0x0E are discarded silently.
package slci_pkg;

    localparam int CLK_HZ = 250_000_000;
    localparam int CLK_NS = 4;

    localparam int BAUD_SLOW = 19_200;
    localparam int BAUD_FAST = 115_200;
    localparam int BIT_CYC_SLOW = CLK_HZ / BAUD_SLOW;
    localparam int BIT_CYC_FAST = CLK_HZ / BAUD_FAST;

    localparam int ENABLE_NS = 3000;
    localparam int ENABLE_CYC = (ENABLE_NS + CLK_NS - 1) / CLK_NS;
    localparam int UNIT_US = 10;
    localparam int UNIT_CYC = (UNIT_US * 1000) / CLK_NS;
    localparam int SHORT_WAIT_US = 80;
    localparam int SHORT_WAIT_CYC = (SHORT_WAIT_US * 1000) / CLK_NS;
    localparam int LONG_WAIT_US = 2700;
    localparam int LONG_WAIT_CYC = (LONG_WAIT_US * 1000) / CLK_NS;

    localparam int CNT_W = 20;
    localparam int BAUD_CNT_W = 16;

    localparam logic [7:0] PFX_LO = 8'h08;
    localparam logic [7:0] PFX_HI = 8'h0f;
    localparam logic [7:0] PFX_INSTR = 8'h08;
    localparam logic [7:0] PFX_DATA = 8'h09;
    localparam logic [7:0] PFX_SINGLE = 8'h0a;
    localparam logic [7:0] PFX_CONT = 8'h0b;
    localparam logic [7:0] PFX_PAUSE = 8'h0c;
    localparam logic [7:0] PFX_RSVD_A = 8'h0d;
    localparam logic [7:0] PFX_RSVD_B = 8'h0e;
    localparam logic [7:0] PFX_RESET = 8'h0f;
    localparam logic [7:0] GLYPH_EXIT = 8'hf0;
    localparam logic [7:0] INSTR_CLEAR = 8'h01;
    localparam logic [7:0] INSTR_HOME = 8'h02;
    localparam logic [7:0] GLYPH_ADDR_LO = 8'h40;
    localparam logic [7:0] GLYPH_ADDR_HI = 8'h7f;

    localparam logic RS_INSTR = 1'b0;
    localparam logic RS_DATA = 1'b1;

    typedef struct packed {
        logic instruction_data_select;
        logic [7:0] lcd_parallel_bus;
        logic enable;
    } slci_lcd_type;

    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } slci_byte_type;

    function automatic logic slci_is_prefix(input logic [7:0] b);
        return (b >= PFX_LO) && (b <= PFX_HI);
    endfunction : slci_is_prefix

endpackage : slci_pkg

// >>> rtl/slci_uart_rx.sv
// Serial 8N1 receiver with two-flop pin synchronisers and rate select.
`timescale 1ns/1ps
module slci_uart_rx #(
    parameter int BIT_CYC_SLOW_P = slci_pkg::BIT_CYC_SLOW
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_rx,
    input wire logic i_baud_fast,
    output slci_pkg::slci_byte_type o_byte,
    output logic o_frame_error
);
    import slci_pkg::*;

    typedef struct packed {
        logic [1:0] sync1;
        logic [1:0] sync2;
        logic busy;
        logic [BAUD_CNT_W-1:0] cnt;
        logic [BAUD_CNT_W-1:0] period;
        logic [3:0] bitn;
        logic [7:0] shreg;
        slci_byte_type out;
        logic ferr;
    } slci_rx_state_type;

    slci_rx_state_type s_reg;
    slci_rx_state_type s_next;
    logic [1:0] pins;
    logic rx_s;
    logic fast_s;

    assign pins = {i_baud_fast, i_rx};
    assign rx_s = s_reg.sync2[0];
    assign fast_s = s_reg.sync2[1];

    always_comb begin
        s_next = s_reg;
        s_next.sync1 = pins;
        s_next.sync2 = s_reg.sync1;
        s_next.out.valid = 1'b0;
        s_next.ferr = 1'b0;
        if (!s_reg.busy) begin
            if (!rx_s) begin
                // The rate is latched per frame so a jumper change never splits a byte.
                s_next.period = fast_s ? BAUD_CNT_W'(BIT_CYC_FAST) : BAUD_CNT_W'(BIT_CYC_SLOW_P);
                s_next.cnt = fast_s ? BAUD_CNT_W'(BIT_CYC_FAST / 2) : BAUD_CNT_W'(BIT_CYC_SLOW_P / 2);
                s_next.bitn = 4'h0;
                s_next.busy = 1'b1;
            end
        end else if (s_reg.cnt != '0) begin
            s_next.cnt = s_reg.cnt - 1'b1;
        end else begin
            s_next.cnt = s_reg.period - 1'b1;
            s_next.bitn = s_reg.bitn + 1'b1;
            if (s_reg.bitn == 4'h0) begin
                if (rx_s) begin
                    s_next.busy = 1'b0;
                end
            end else if (s_reg.bitn <= 4'h8) begin
                s_next.shreg = {rx_s, s_reg.shreg[7:1]};
            end else begin
                s_next.busy = 1'b0;
                s_next.out.valid = rx_s;
                s_next.out.data = s_reg.shreg;
                s_next.ferr = !rx_s;
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            s_reg <= '{sync1: 2'h1, sync2: 2'h1, default: '0};
        end else begin
            s_reg <= s_next;
        end
    end

    assign o_byte = s_reg.out;
    assign o_frame_error = s_reg.ferr;

endmodule : slci_uart_rx

// >>> rtl/slci_top.sv
// Command interpreter that turns serial bytes into character display writes.
`timescale 1ns/1ps
module slci_top #(
    parameter int BIT_CYC_SLOW_P = slci_pkg::BIT_CYC_SLOW,
    parameter int SHORT_WAIT_CYC_P = slci_pkg::SHORT_WAIT_CYC,
    parameter int LONG_WAIT_CYC_P = slci_pkg::LONG_WAIT_CYC
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_rx,
    input wire logic i_baud_fast,
    output slci_pkg::slci_lcd_type o_lcd,
    output logic o_glyph_mode,
    output logic o_busy,
    output logic o_overrun,
    output logic o_frame_error
);
    import slci_pkg::*;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_VALUE = 3'h1,
        ST_SETUP = 3'h3,
        ST_STROBE = 3'h2,
        ST_WAIT = 3'h6
    } slci_fsm_type;

    typedef struct packed {
        slci_fsm_type state;
        slci_byte_type pend;
        logic [7:0] prefix;
        logic glyph;
        logic single_valid;
        logic [7:0] single_val;
        logic [7:0] cont_val;
        slci_lcd_type lcd;
        logic [CNT_W-1:0] cnt;
        logic [CNT_W-1:0] wait_cyc;
        logic overrun;
    } slci_state_type;

    slci_state_type s_reg;
    slci_state_type s_next;
    slci_byte_type rx_byte;
    logic rx_ferr;

    slci_uart_rx #(
        .BIT_CYC_SLOW_P(BIT_CYC_SLOW_P)
    ) u_rx (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_rx(i_rx),
        .i_baud_fast(i_baud_fast),
        .o_byte(rx_byte),
        .o_frame_error(rx_ferr)
    );

    // Scales a delay byte into clock cycles in 10 us units.
    function automatic logic [CNT_W-1:0] unit_cycles(input logic [7:0] v);
        return CNT_W'(v) * CNT_W'(UNIT_CYC);
    endfunction : unit_cycles

    // Picks the settle time that follows a write of this kind and value.
    function automatic logic [CNT_W-1:0] settle_cycles(
        input logic is_instr,
        input logic [7:0] v,
        input logic single_valid,
        input logic [7:0] single_val,
        input logic [7:0] cont_val
    );
        logic long_op;
        long_op = is_instr && ((v == INSTR_CLEAR) || (v == INSTR_HOME));
        if (single_valid && (single_val != 8'h00)) begin
            return unit_cycles(single_val);
        end else if (long_op) begin
            return CNT_W'(LONG_WAIT_CYC_P);
        end else if (cont_val != 8'h00) begin
            return unit_cycles(cont_val);
        end else begin
            return CNT_W'(SHORT_WAIT_CYC_P);
        end
    endfunction : settle_cycles

    logic take;
    logic [7:0] b;

    assign b = s_reg.pend.data;

    always_comb begin
        s_next = s_reg;
        s_next.overrun = 1'b0;
        take = 1'b0;

        unique case (s_reg.state)
            ST_IDLE: begin
                if (s_reg.pend.valid) begin
                    take = 1'b1;
                    if (s_reg.glyph) begin
                        if (b == GLYPH_EXIT) begin
                            s_next.glyph = 1'b0;
                        end else begin
                            // Glyph rows may fall in the prefix range, so no decoding here.
                            s_next.lcd.instruction_data_select = RS_DATA;
                            s_next.lcd.lcd_parallel_bus = b;
                            s_next.state = ST_SETUP;
                        end
                    end else if (slci_is_prefix(b)) begin
                        if (b == PFX_RESET) begin
                            // Soft reset: sequence, glyph mode and delays back to defaults.
                            s_next.glyph = 1'b0;
                            s_next.single_valid = 1'b0;
                            s_next.single_val = 8'h00;
                            s_next.cont_val = 8'h00;
                            s_next.prefix = 8'h00;
                        end else begin
                            // Reserved prefixes also swallow one value byte, so later bytes stay paired.
                            s_next.prefix = b;
                            s_next.state = ST_VALUE;
                        end
                    end else begin
                        s_next.lcd.instruction_data_select = RS_DATA;
                        s_next.lcd.lcd_parallel_bus = b;
                        s_next.state = ST_SETUP;
                    end
                end
            end

            ST_VALUE: begin
                if (s_reg.pend.valid) begin
                    take = 1'b1;
                    s_next.state = ST_IDLE;
                    unique case (s_reg.prefix)
                        PFX_INSTR: begin
                            s_next.lcd.instruction_data_select = RS_INSTR;
                            s_next.lcd.lcd_parallel_bus = b;
                            s_next.state = ST_SETUP;
                            if ((b >= GLYPH_ADDR_LO) && (b <= GLYPH_ADDR_HI)) begin
                                s_next.glyph = 1'b1;
                            end
                        end
                        PFX_DATA: begin
                            s_next.lcd.instruction_data_select = RS_DATA;
                            s_next.lcd.lcd_parallel_bus = b;
                            s_next.state = ST_SETUP;
                        end
                        PFX_SINGLE: begin
                            s_next.single_valid = 1'b1;
                            s_next.single_val = b;
                        end
                        PFX_CONT: begin
                            s_next.cont_val = b;
                        end
                        PFX_PAUSE: begin
                            if (b != 8'h00) begin
                                s_next.cnt = unit_cycles(b) - 1'b1;
                                s_next.state = ST_WAIT;
                            end
                        end
                        PFX_RSVD_A, PFX_RSVD_B: begin
                            s_next.state = ST_IDLE;
                        end
                        default: begin
                            s_next.state = ST_IDLE;
                        end
                    endcase
                end
            end

            ST_SETUP: begin
                // Select and data settle one cycle before the strobe rises.
                s_next.wait_cyc = settle_cycles(s_reg.lcd.instruction_data_select == RS_INSTR,
                    s_reg.lcd.lcd_parallel_bus, s_reg.single_valid, s_reg.single_val,
                    s_reg.cont_val);
                s_next.single_valid = 1'b0;
                s_next.lcd.enable = 1'b1;
                s_next.cnt = CNT_W'(ENABLE_CYC - 1);
                s_next.state = ST_STROBE;
            end

            ST_STROBE: begin
                if (s_reg.cnt != '0) begin
                    s_next.cnt = s_reg.cnt - 1'b1;
                end else begin
                    s_next.lcd.enable = 1'b0;
                    s_next.cnt = s_reg.wait_cyc - 1'b1;
                    s_next.state = ST_WAIT;
                end
            end

            ST_WAIT: begin
                if (s_reg.cnt != '0) begin
                    s_next.cnt = s_reg.cnt - 1'b1;
                end else begin
                    s_next.state = ST_IDLE;
                end
            end

            default: begin
                s_next.state = ST_IDLE;
            end
        endcase

        // A single byte is held while the display is busy; a second one replaces it.
        if (rx_byte.valid) begin
            s_next.pend = rx_byte;
            s_next.overrun = s_reg.pend.valid && !take;
        end else if (take) begin
            s_next.pend.valid = 1'b0;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            s_reg <= '{state: ST_IDLE, default: '0};
        end else begin
            s_reg <= s_next;
        end
    end

    assign o_lcd = s_reg.lcd;
    assign o_glyph_mode = s_reg.glyph;
    assign o_busy = (s_reg.state != ST_IDLE) && (s_reg.state != ST_VALUE);
    assign o_overrun = s_reg.overrun;
    assign o_frame_error = rx_ferr;

endmodule : slci_top

// >>> verification/slci_host_model.sv
// Host side model that frames bytes onto the serial receive line.
`timescale 1ns/1ps
module slci_host_model (
    input wire logic i_clk,
    output logic o_tx
);
    initial begin
        o_tx = 1'b1;
    end

    // Start bit, eight data bits LSB first, then one stop bit; a low stop bit models a framing fault.
    task automatic send(input logic [7:0] b, input int bit_cyc, input logic stop_ok);
        logic [9:0] frame;
        frame = {stop_ok, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(negedge i_clk);
            o_tx = frame[i];
            repeat (bit_cyc - 1) @(negedge i_clk);
        end
        @(negedge i_clk);
        o_tx = 1'b1;
    endtask : send
endmodule : slci_host_model

// >>> verification/slci_top_properties.sv
// Concurrent checks on the display write port of the command interpreter.
`timescale 1ns/1ps
module slci_top_properties #(
    parameter int BIT_CYC_SLOW_P = 13020,
    parameter int SHORT_WAIT_CYC_P = 20000,
    parameter int LONG_WAIT_CYC_P = 675000
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_rx,
    input wire logic i_baud_fast,
    input wire slci_pkg::slci_lcd_type o_lcd,
    input wire logic o_glyph_mode,
    input wire logic o_busy,
    input wire logic o_overrun,
    input wire logic o_frame_error
);
    import slci_pkg::*;
    // A delay command may shorten the settle time to one 10 us unit, below the default wait.
    localparam int MIN_GAP = (SHORT_WAIT_CYC_P < UNIT_CYC) ? SHORT_WAIT_CYC_P : UNIT_CYC;
    logic [9:0] en_cnt_reg;
    logic [19:0] gap_reg;

    // The gap counter saturates so a long quiet spell never wraps into a false short gap.
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            en_cnt_reg <= '0;
            gap_reg <= '1;
        end else begin
            en_cnt_reg <= o_lcd.enable ? en_cnt_reg + 10'h001 : '0;
            gap_reg <= o_lcd.enable ? '0 : ((&gap_reg) ? gap_reg : gap_reg + 20'h00001);
        end
    end

    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    chk_en_length: assert property ($fell(o_lcd.enable) |-> en_cnt_reg == 10'h2ee)
        else $error("enable pulse length wrong");
    chk_en_bound: assert property (en_cnt_reg <= 10'h2ee)
        else $error("enable pulse too long");
    chk_bus_hold: assert property (o_lcd.enable |->
        $stable(o_lcd.lcd_parallel_bus) && $stable(o_lcd.instruction_data_select))
        else $error("bus or select moved around enable");
    chk_idle_stand: assert property (!o_busy |-> $stable(o_lcd))
        else $error("display port changed while idle");
    chk_write_busy: assert property (o_lcd.enable |-> o_busy)
        else $error("enable high while not busy");
    chk_write_gap: assert property ($rose(o_lcd.enable) |-> gap_reg >= MIN_GAP)
        else $error("writes closer than the wait time");
    chk_reset_idle: assert property ($rose(i_rst_n) |-> o_lcd == '0 && !o_busy && !o_glyph_mode)
        else $error("outputs not idle after reset");
    chk_glyph_entry: assert property ($rose(o_glyph_mode) |-> ##[0:3]
        (o_lcd.instruction_data_select == RS_INSTR && o_lcd.lcd_parallel_bus[7:6] == 2'h1))
        else $error("glyph mode without glyph address");
    // A byte held behind the exit byte may start its own write one cycle later, so busy is checked only in the exit slot.
    chk_glyph_exit: assert property ($fell(o_glyph_mode) |-> !o_busy && !o_lcd.enable ##1 !o_lcd.enable)
        else $error("exit byte was written");

    cover property ($rose(o_glyph_mode));
    cover property ($fell(o_lcd.enable));
    cover property (o_overrun);
    cover property (o_frame_error);
endmodule : slci_top_properties

bind slci_top slci_top_properties #(.BIT_CYC_SLOW_P(BIT_CYC_SLOW_P), .SHORT_WAIT_CYC_P(SHORT_WAIT_CYC_P),
    .LONG_WAIT_CYC_P(LONG_WAIT_CYC_P)) u_props (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_rx(i_rx),
    .i_baud_fast(i_baud_fast), .o_lcd(o_lcd), .o_glyph_mode(o_glyph_mode), .o_busy(o_busy),
    .o_overrun(o_overrun), .o_frame_error(o_frame_error));

// >>> verification/slci_top_tb.sv
// Self-checking bench for the serial command interpreter.
`timescale 1ns/1ps
module slci_top_tb;
    import slci_pkg::*;
    localparam int BIT_P = 16;
    localparam int SH = 20;
    localparam int LG = 60;
    localparam int UNIT = 2500;
    typedef struct {
        int nb;
        logic [23:0] b;
        int nw;
        logic [17:0] w;
        logic g;
        int wt;
    } slci_row_type;
    logic i_clk, i_rst_n, i_rx, i_baud_fast, o_glyph_mode, o_busy, o_overrun, o_frame_error, en_d;
    slci_lcd_type o_lcd;
    slci_row_type rows [25];
    logic [8:0] wq [$];
    int n_mismatch, checks, n_ovr, n_fe, wcnt, bit_c;

    slci_top #(.BIT_CYC_SLOW_P(BIT_P), .SHORT_WAIT_CYC_P(SH), .LONG_WAIT_CYC_P(LG)) u_dut (.i_clk(i_clk),
        .i_rst_n(i_rst_n), .i_rx(i_rx), .i_baud_fast(i_baud_fast), .o_lcd(o_lcd), .o_glyph_mode(o_glyph_mode),
        .o_busy(o_busy), .o_overrun(o_overrun), .o_frame_error(o_frame_error));
    slci_host_model u_host (.i_clk(i_clk), .o_tx(i_rx));

    initial begin
        i_clk = 1'b0;
    end
    always #2 i_clk = ~i_clk;

    // Records each write at its strobe and counts busy cycles after the strobe falls.
    always @(posedge i_clk) begin
        if (o_lcd.enable && !en_d) wq.push_back({o_lcd.instruction_data_select, o_lcd.lcd_parallel_bus});
        if (en_d && !o_lcd.enable) wcnt <= 1;
        else if (o_busy) wcnt <= wcnt + 1;
        if (o_overrun) n_ovr++;
        if (o_frame_error) n_fe++;
        en_d <= o_lcd.enable;
    end

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %0h seen %0h", name, exp, seen);
        end
    endtask : check

    task automatic end_of_test();
        $display("checks %0d n_mismatch %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : end_of_test

    task automatic wait_idle();
        int k;
        k = 0;
        while (o_busy !== 1'b0 && k < 20000) begin
            @(negedge i_clk);
            k++;
        end
        if (k == 20000) check("idle", 1'b0, 1'b1);
    endtask : wait_idle

    task automatic tx(input logic [7:0] b);
        u_host.send(b, bit_c, 1'b1);
        repeat (4) @(negedge i_clk);
        wait_idle();
    endtask : tx

    initial begin
        repeat (90000) @(posedge i_clk);
        n_mismatch++;
        end_of_test();
    end

    initial begin
        i_rst_n = 1'b0;
        i_baud_fast = 1'b0;
        bit_c = BIT_P;
        // Row fields: byte count, bytes, write count, writes as {select, bus}, glyph mode after, wait.
        rows = '{'{2, 24'h000838, 1, 18'h00038, 0, SH}, '{1, 24'h000041, 1, 18'h00141, 0, SH},
            '{1, 24'h000007, 1, 18'h00107, 0, 0}, '{1, 24'h000010, 1, 18'h00110, 0, 0},
            '{1, 24'h0000ff, 1, 18'h001ff, 0, 0}, '{2, 24'h000880, 1, 18'h00080, 0, SH},
            '{2, 24'h00090f, 1, 18'h0010f, 0, 0}, '{3, 24'h090841, 2, 18'h21141, 0, 0},
            '{2, 24'h000d41, 0, 18'h0, 0, 0}, '{2, 24'h000e41, 0, 18'h0, 0, 0},
            '{1, 24'h00000f, 0, 18'h0, 0, 0}, '{3, 24'h0b0541, 1, 18'h00141, 0, 5 * UNIT},
            '{2, 24'h000801, 1, 18'h00001, 0, LG}, '{3, 24'h0b0041, 1, 18'h00141, 0, SH},
            '{3, 24'h0a0141, 1, 18'h00141, 0, UNIT}, '{1, 24'h000042, 1, 18'h00142, 0, SH},
            '{2, 24'h000802, 1, 18'h00002, 0, LG}, '{2, 24'h000c01, 0, 18'h0, 0, 0},
            '{2, 24'h00083f, 1, 18'h0003f, 0, 0}, '{3, 24'h08401f, 2, 18'h0811f, 1, 0},
            '{1, 24'h00000f, 1, 18'h0010f, 1, 0}, '{1, 24'h0000f0, 0, 18'h0, 0, 0},
            '{3, 24'h087ff0, 1, 18'h0007f, 0, 0}, '{3, 24'h0b050f, 0, 18'h0, 0, 0},
            '{1, 24'h000042, 1, 18'h00142, 0, SH}};
        repeat (6) @(negedge i_clk);
        check("reset lcd", o_lcd, 10'h000);
        i_rst_n = 1'b1;
        repeat (50) @(negedge i_clk);
        foreach (rows[r]) begin
            wq.delete();
            for (int i = 0; i < rows[r].nb; i++) tx(rows[r].b[8 * (rows[r].nb - 1 - i) +: 8]);
            check("writes", wq.size(), rows[r].nw);
            for (int k = 0; k < rows[r].nw; k++) begin
                check("write", wq[k], rows[r].w[9 * (rows[r].nw - 1 - k) +: 9]);
            end
            check("glyph", o_glyph_mode, rows[r].g);
            if (rows[r].wt > 0) check("wait", wcnt >= rows[r].wt && wcnt <= rows[r].wt + 3, 1'b1);
        end
        // A hardware reset in mid-sequence must drop the pending instruction prefix.
        tx(8'h08);
        i_rst_n = 1'b0;
        @(negedge i_clk);
        check("reset mid", o_lcd, 10'h000);
        i_rst_n = 1'b1;
        wq.delete();
        tx(8'h41);
        check("after reset", wq[0], 9'h141);
        // Bytes arriving during the enable strobe of one write: the newest one wins, no extra write.
        n_ovr = 0;
        tx(8'h0a);
        tx(8'h01);
        wq.delete();
        u_host.send(8'h41, bit_c, 1'b1);
        u_host.send(8'h42, bit_c, 1'b1);
        tx(8'h43);
        repeat (4) @(negedge i_clk);
        wait_idle();
        check("overrun", n_ovr, 1);
        check("kept", wq.size() == 2 ? wq[1] : 9'h000, 9'h143);
        n_fe = 0;
        wq.delete();
        u_host.send(8'h41, bit_c, 1'b0);
        repeat (2 * BIT_P) @(negedge i_clk);
        check("frame", n_fe, 1);
        check("dropped", wq.size(), 0);
        i_baud_fast = 1'b1;
        bit_c = BIT_CYC_FAST;
        tx(8'h5a);
        check("fast", wq[0], 9'h15a);
        end_of_test();
    end
endmodule : slci_top_tb
